// ===== dual_link_pkg.sv
// Constants, word layouts and state codes for the expansion link block
package dual_link_pkg;

   localparam int LINK_WIDTH = 8;
   localparam int CONNECTOR_PINS = 15;
   localparam int LINK_BYTE_ADDR = 2;
   localparam int SENSOR_COUNT = 5;
   localparam int MOTOR_COUNT = 4;
   localparam int RESULT_BIT = 0;

   localparam real CLOCK_MHZ = 40.0;
   localparam real LINK_DELAY_US = 7.8;
   localparam int LINK_DELAY_CYCLES = int'(LINK_DELAY_US * CLOCK_MHZ);

   localparam logic [LINK_WIDTH-1:0] RESET_LINK = 8'h00;
   localparam logic [LINK_WIDTH-1:0] RESET_OE_B = 8'hFF;
   localparam logic [MOTOR_COUNT-1:0] RESET_MOTORS = 4'h0;

   typedef struct packed {
      logic stopCmd;
      logic runCmd;
   } control_word_t;

   typedef struct packed {
      logic configConflict;
      logic faulted;
      logic running;
   } status_word_t;

   localparam status_word_t RESET_STATUS = 3'h0;

   typedef enum logic [1:0] {
      RUN_STOPPED = 2'b01,
      RUN_ACTIVE = 2'b10
   } run_state_t;

endpackage

// ===== dual_module_expansion_link.sv
// Expansion link, run/stop control and shutdown logic of one linked module
// How it works
// - The link carries eight parallel binary signals between the two modules.
// - A link bit reaches the receiving program image 7.8 us after it arrives.
// - The link and the differential inputs are never active together, link wins.
// - Control and status words are taken and shown only at the cyclic data strobe.
// - Bit parameters in and out are exchanged only at the cyclic data strobe.
// - Eight connector pins form the link, each usable as input or output.
// - Link inputs map to program input byte 2 and outputs to output byte 2.
// - Each link pin is either an input or an output, never both.
// - The receiver ANDs enable, five sensors and the partner result into four motors.
// - The motor report to the CPU is updated only at the next data exchange.
// - The sender ANDs its five sensors and drives the result on link bit 0.
`timescale 1ns/1ps
module dual_module_expansion_link
   import dual_link_pkg::*;
#(
   parameter int WIDTH = LINK_WIDTH,
   parameter int SENSORS = SENSOR_COUNT,
   parameter int MOTORS = MOTOR_COUNT,
   parameter int DELAY_CYCLES = LINK_DELAY_CYCLES
) (
   input wire logic clock, // 40 MHz system clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic linkRequest, // Configure pins as expansion link
   input wire logic diffRequest, // Configure differential inputs
   input wire logic [WIDTH-1:0] linkDirOut, // Per pin: 1 output, 0 input
   input wire logic roleReceiver, // 1 receiving module, 0 sending module
   input wire logic [WIDTH-1:0] linkPinIn, // Link pin input levels
   output logic [WIDTH-1:0] linkPinOut, // Link pin output levels
   output logic [WIDTH-1:0] linkPinOe_b, // Link pin drive enable, low drives
   input wire logic [WIDTH-1:0] progLinkOut, // Program output byte 2 image
   output logic [WIDTH-1:0] progLinkIn, // Program input byte 2 image
   input wire logic [SENSORS-1:0] sensorIn, // Proximity sensor inputs
   output logic [MOTORS-1:0] motorOut, // Motor drive outputs
   input wire logic dataCycle, // One-cycle strobe per CPU data cycle
   input wire control_word_t ctrlWordIn, // Control word from CPU
   input wire logic enableParamIn, // Enable bit parameter from CPU
   output status_word_t statusWordOut, // Status word to CPU
   output logic motorReportOut, // Motor on/off bit parameter to CPU
   input wire logic faultIn, // Local fault, forces stop
   output logic linkActive, // Expansion link in use
   output logic diffActive // Differential inputs in use
);

   initial begin
      if (WIDTH != LINK_WIDTH) begin
         $error("dual_module_expansion_link: link must be eight bits wide");
      end
      if (DELAY_CYCLES < 3) begin
         $error("dual_module_expansion_link: DELAY_CYCLES must be at least 3");
      end
      if (SENSORS < 1 || MOTORS < 1) begin
         $error("dual_module_expansion_link: need sensors and motors");
      end
   end

   // Receive path: ring delay plus the image register
   logic [WIDTH-1:0] delayedPins;

   link_delay_line #(
      .WIDTH(WIDTH),
      .DEPTH(DELAY_CYCLES - 2)
   ) u_rx_delay (
      .clock(clock),
      .rst_b(rst_b),
      .din(linkPinIn),
      .dout(delayedPins)
   );

   // Pin configuration
   logic next_linkActive;
   logic next_diffActive;
   logic configConflict;
   logic [WIDTH-1:0] outMask;
   logic [WIDTH-1:0] next_linkPinOut;
   logic [WIDTH-1:0] next_linkPinOe_b;
   logic [WIDTH-1:0] next_progLinkIn;
   logic logic_operation_result;
   logic [WIDTH-1:0] outImage;

   always_comb begin
      next_linkActive = linkRequest;
      next_diffActive = diffRequest & ~linkRequest;
      configConflict = linkRequest & diffRequest;
      logic_operation_result = &sensorIn;
      outImage = progLinkOut;
      if (!roleReceiver) begin
         outImage[RESULT_BIT] = logic_operation_result;
      end
      outMask = linkDirOut & {WIDTH{next_linkActive}};
      next_linkPinOut = outImage & outMask;
      next_linkPinOe_b = ~outMask;
      next_progLinkIn = delayedPins & ~linkDirOut & {WIDTH{linkActive}};
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         linkActive <= 1'b0;
         diffActive <= 1'b0;
         linkPinOut <= RESET_LINK;
         linkPinOe_b <= RESET_OE_B;
         progLinkIn <= RESET_LINK;
      end else begin
         linkActive <= next_linkActive;
         diffActive <= next_diffActive;
         linkPinOut <= next_linkPinOut;
         linkPinOe_b <= next_linkPinOe_b;
         progLinkIn <= next_progLinkIn;
      end
   end

   // Run/stop state and cyclic exchange
   run_state_t runState;
   run_state_t next_runState;
   logic enableParam;
   logic next_enableParam;
   logic faultSticky;
   logic next_faultSticky;
   status_word_t next_statusWordOut;
   logic next_motorReportOut;

   always_comb begin
      next_runState = runState;
      next_enableParam = enableParam;
      next_statusWordOut = statusWordOut;
      next_motorReportOut = motorReportOut;
      next_faultSticky = faultSticky;
      if (dataCycle) begin
         next_enableParam = enableParamIn;
         next_motorReportOut = |motorOut;
         next_statusWordOut.running = (runState == RUN_ACTIVE);
         next_statusWordOut.faulted = faultSticky;
         next_statusWordOut.configConflict = configConflict;
         if (ctrlWordIn.stopCmd) begin
            next_runState = RUN_STOPPED;
         end else if (ctrlWordIn.runCmd) begin
            next_runState = RUN_ACTIVE;
            next_faultSticky = 1'b0;
         end
      end
      // Fault stop and its flag win over a run command in the same cycle
      if (faultIn) begin
         next_runState = RUN_STOPPED;
         next_faultSticky = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         runState <= RUN_STOPPED;
         enableParam <= 1'b0;
         faultSticky <= 1'b0;
         statusWordOut <= RESET_STATUS;
         motorReportOut <= 1'b0;
      end else begin
         runState <= next_runState;
         enableParam <= next_enableParam;
         faultSticky <= next_faultSticky;
         statusWordOut <= next_statusWordOut;
         motorReportOut <= next_motorReportOut;
      end
   end

   // Fast shutdown of the motors
   logic motorsOn;
   logic [MOTORS-1:0] next_motorOut;

   always_comb begin
      motorsOn = roleReceiver & (runState == RUN_ACTIVE) & enableParam
         & logic_operation_result & progLinkIn[RESULT_BIT];
      next_motorOut = {MOTORS{motorsOn}};
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         motorOut <= RESET_MOTORS;
      end else begin
         motorOut <= next_motorOut;
      end
   end

   // Checking
   logic [8:0] warmCount;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         warmCount <= '0;
      end else if (warmCount != 9'h137) begin
         warmCount <= warmCount + 1'b1;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   generate
      if (DELAY_CYCLES == 312) begin : g_delay_check
         property p_delay;
            (warmCount == 9'h137) |-> (delayedPins == $past(linkPinIn, 311));
         endproperty
         a_delay: assert property (p_delay) else $error("link delay wrong");
      end
   endgenerate

   property p_exclusive;
      !(linkActive && diffActive);
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("link and diff both on");

   property p_link_wins;
      (linkRequest && diffRequest) |=> (linkActive && !diffActive);
   endproperty
   a_link_wins: assert property (p_link_wins) else $error("conflict not resolved");

   property p_oe_dir;
      1'b1 |=> (linkPinOe_b == ~($past(linkDirOut) & {WIDTH{$past(linkRequest)}}));
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("pin enable mismatch");

   property p_in_masked;
      1'b1 |=> ((progLinkIn & $past(linkDirOut)) == '0);
   endproperty
   a_in_masked: assert property (p_in_masked) else $error("output pin read as input");

   property p_sender_bit0;
      (!roleReceiver && linkRequest && linkDirOut[RESULT_BIT])
         |=> (linkPinOut[RESULT_BIT] == &$past(sensorIn));
   endproperty
   a_sender_bit0: assert property (p_sender_bit0) else $error("result not on bit 0");

   property p_shutdown;
      (!(&sensorIn) || !progLinkIn[RESULT_BIT]) |=> (motorOut == '0);
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("motors not shut down");

   property p_report_lag;
      !dataCycle |=> $stable(motorReportOut) && $stable(statusWordOut);
   endproperty
   a_report_lag: assert property (p_report_lag) else $error("report moved off cycle");

   property p_ctrl_sync;
      (!dataCycle && !faultIn) |=> $stable(runState);
   endproperty
   a_ctrl_sync: assert property (p_ctrl_sync) else $error("state moved off cycle");

   property p_param_sync;
      !dataCycle |=> $stable(enableParam);
   endproperty
   a_param_sync: assert property (p_param_sync) else $error("param moved off cycle");

   property p_fault_stop;
      faultIn |=> (runState == RUN_STOPPED) ##1 (motorOut == '0);
   endproperty
   a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop");

   property p_pin_quiet;
      (linkPinOut & linkPinOe_b) == '0;
   endproperty
   a_pin_quiet: assert property (p_pin_quiet) else $error("released pin not low");

   property p_diff_alone;
      (diffRequest && !linkRequest) |=> diffActive;
   endproperty
   a_diff_alone: assert property (p_diff_alone) else $error("diff inputs not granted");

   property p_link_idle;
      !linkActive |=> (progLinkIn == '0);
   endproperty
   a_link_idle: assert property (p_link_idle) else $error("image set while idle");

   property p_sender_still;
      !roleReceiver |=> (motorOut == '0);
   endproperty
   a_sender_still: assert property (p_sender_still) else $error("sender drove motors");

   property p_report_value;
      dataCycle |=> (motorReportOut == ($past(motorOut) != '0));
   endproperty
   a_report_value: assert property (p_report_value) else $error("report value wrong");

   property p_status_conflict;
      dataCycle |=> (statusWordOut.configConflict
         == ($past(linkRequest) && $past(diffRequest)));
   endproperty
   a_status_conflict: assert property (p_status_conflict) else $error("conflict bit wrong");

   property p_stop_cmd;
      (dataCycle && ctrlWordIn.stopCmd) |=> (runState == RUN_STOPPED);
   endproperty
   a_stop_cmd: assert property (p_stop_cmd) else $error("stop not taken");

   property p_run_cmd;
      (dataCycle && ctrlWordIn.runCmd && !ctrlWordIn.stopCmd && !faultIn)
         |=> (runState == RUN_ACTIVE);
   endproperty
   a_run_cmd: assert property (p_run_cmd) else $error("run not taken");

   property p_param_take;
      dataCycle |=> (enableParam == $past(enableParamIn));
   endproperty
   a_param_take: assert property (p_param_take) else $error("param not taken");

   c_motor_on: cover property (motorOut != '0);
   c_fault: cover property (faultIn && (motorOut != '0));
   c_shutdown: cover property ((motorOut != '0) ##1 (motorOut == '0));
   c_report: cover property (dataCycle ##1 motorReportOut);
   c_conflict: cover property (linkRequest && diffRequest);

endmodule // dual_module_expansion_link

// ===== dual_module_expansion_link_tb_top.sv
// Self-checking testbench of the expansion link block with a partner model
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module dual_module_expansion_link_tb_top;
   import dual_link_pkg::*;
   localparam int D = 8;
   logic clock = 1'h0, rst_b = 1'h0, linkRequest = 1'h0, diffRequest = 1'h0;
   logic roleReceiver = 1'h0, dataCycle = 1'h0, enableParamIn = 1'h0, faultIn = 1'h0;
   logic [7:0] linkDirOut = 8'h00, progLinkOut = 8'h00, pOut = 8'h00, pDir = 8'hF0;
   logic [4:0] sensorIn = 5'h1F, pSensors = 5'h1F;
   control_word_t ctrlWordIn = 2'h0;
   logic [7:0] linkPinIn, linkPinOut, linkPinOe_b, progLinkIn, pinLevel;
   logic [3:0] motorOut;
   status_word_t statusWordOut;
   logic motorReportOut, linkActive, diffActive;
   int failures = 0;
   int cmp_count = 0;

   // Wire level: the driving party wins on each pin
   assign linkPinIn = (~linkPinOe_b & linkPinOut) | (linkPinOe_b & pinLevel);

   dual_module_expansion_link #(.DELAY_CYCLES(D)) dut_u (
      .clock(clock), .rst_b(rst_b), .linkRequest(linkRequest), .diffRequest(diffRequest),
      .linkDirOut(linkDirOut), .roleReceiver(roleReceiver), .linkPinIn(linkPinIn),
      .linkPinOut(linkPinOut), .linkPinOe_b(linkPinOe_b), .progLinkOut(progLinkOut),
      .progLinkIn(progLinkIn), .sensorIn(sensorIn), .motorOut(motorOut),
      .dataCycle(dataCycle), .ctrlWordIn(ctrlWordIn), .enableParamIn(enableParamIn),
      .statusWordOut(statusWordOut), .motorReportOut(motorReportOut), .faultIn(faultIn),
      .linkActive(linkActive), .diffActive(diffActive)
   );

   link_partner_model partner_u (
      .clock(clock), .sensors(pSensors), .progOut(pOut), .dirOut(pDir), .pinLevel(pinLevel)
   );

   initial begin
      forever #12.5 clock = ~clock;
   end

   task automatic close_out;
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic strobe(input logic run, input logic stop, input logic en);
      @(posedge clock);
      dataCycle <= 1'h1;
      ctrlWordIn <= '{stopCmd: stop, runCmd: run};
      enableParamIn <= en;
      @(posedge clock);
      dataCycle <= 1'h0;
      #1;
   endtask

   task automatic t_reset;
      `CHK("oe_b", RESET_OE_B, linkPinOe_b)
      `CHK("pin out", RESET_LINK, linkPinOut)
      `CHK("motors", RESET_MOTORS, motorOut)
      `CHK("status", RESET_STATUS, statusWordOut)
      `CHK("image", RESET_LINK, progLinkIn)
      `CHK("report", 1'h0, motorReportOut)
   endtask

   task automatic t_config;
      @(posedge clock);
      linkRequest <= 1'h1;
      diffRequest <= 1'h1;
      linkDirOut <= 8'h0F;
      tick(1);
      `CHK("link active", 1'h1, linkActive)
      `CHK("diff active", 1'h0, diffActive)
      strobe(1'h0, 1'h0, 1'h0);
      `CHK("conflict", 1'h1, statusWordOut.configConflict)
      @(posedge clock);
      linkRequest <= 1'h0;
      tick(1);
      `CHK("diff alone", 1'h1, diffActive)
      `CHK("oe idle", 8'hFF, linkPinOe_b)
      @(posedge clock);
      linkRequest <= 1'h1;
      diffRequest <= 1'h0;
      tick(1);
   endtask

   task automatic t_drive;
      @(posedge clock);
      progLinkOut <= 8'hA5;
      tick(1);
      `CHK("oe dir", 8'hF0, linkPinOe_b)
      `CHK("pin out", 8'h05, linkPinOut)
      @(posedge clock);
      sensorIn <= 5'h1E;
      tick(1);
      `CHK("result bit", 8'h04, linkPinOut)
   endtask

   task automatic t_receive;
      @(posedge clock);
      roleReceiver <= 1'h1;
      sensorIn <= 5'h1F;
      linkDirOut <= 8'h00;
      pDir <= 8'hFF;
      pOut <= 8'h3C;
      tick(D + 4);
      `CHK("in image", 8'h3D, progLinkIn)
      @(posedge clock);
      pOut <= 8'hC2;
      pSensors <= 5'h1E;
      tick(D - 1);
      `CHK("before delay", 8'h3D, progLinkIn)
      tick(1);
      `CHK("after delay", 8'hC2, progLinkIn)
      @(posedge clock);
      linkDirOut <= 8'h80;
      pDir <= 8'h7F;
      tick(D + 3);
      `CHK("masked out", 8'h42, progLinkIn)
      @(posedge clock);
      linkDirOut <= 8'h00;
      pDir <= 8'hFF;
      pSensors <= 5'h1F;
      tick(D + 3);
   endtask

   task automatic t_cycle;
      @(posedge clock);
      ctrlWordIn <= '{stopCmd: 1'h0, runCmd: 1'h1};
      enableParamIn <= 1'h1;
      tick(4);
      `CHK("no strobe", 4'h0, motorOut)
      strobe(1'h1, 1'h0, 1'h1);
      `CHK("lag run", 1'h0, statusWordOut.running)
      tick(1);
      `CHK("motors on", 4'hF, motorOut)
      `CHK("report lag", 1'h0, motorReportOut)
      strobe(1'h1, 1'h0, 1'h1);
      `CHK("report", 1'h1, motorReportOut)
      `CHK("running", 1'h1, statusWordOut.running)
      @(posedge clock);
      enableParamIn <= 1'h0;
      tick(3);
      `CHK("param held", 4'hF, motorOut)
      @(posedge clock);
      sensorIn <= 5'h1B;
      tick(1);
      `CHK("local trip", 4'h0, motorOut)
      @(posedge clock);
      sensorIn <= 5'h1F;
      pSensors <= 5'h0F;
      tick(D + 3);
      `CHK("partner trip", 4'h0, motorOut)
      @(posedge clock);
      pSensors <= 5'h1F;
      tick(D + 3);
      `CHK("restored", 4'hF, motorOut)
      strobe(1'h1, 1'h1, 1'h1);
      tick(1);
      `CHK("stop wins", 4'h0, motorOut)
      strobe(1'h1, 1'h0, 1'h0);
      tick(1);
      `CHK("no enable", 4'h0, motorOut)
      strobe(1'h1, 1'h0, 1'h1);
      tick(1);
      `CHK("rerun", 4'hF, motorOut)
      @(posedge clock);
      faultIn <= 1'h1;
      tick(2);
      `CHK("fault trip", 4'h0, motorOut)
      @(posedge clock);
      faultIn <= 1'h0;
      strobe(1'h0, 1'h1, 1'h1);
      `CHK("faulted", 1'h1, statusWordOut.faulted)
      `CHK("no conflict", 1'h0, statusWordOut.configConflict)
      `CHK("stopped", 1'h0, statusWordOut.running)
   endtask

   initial begin
      #(25 * 4000);
      failures++;
      close_out();
   end

   initial begin
      repeat (3) @(posedge clock);
      #1;
      t_reset();
      @(posedge clock);
      rst_b <= 1'h1;
      t_config();
      t_drive();
      t_receive();
      t_cycle();
      close_out();
   end
endmodule // dual_module_expansion_link_tb_top

// ===== link_delay_line.sv
// Fixed delay line for the link bits, a ring of flip-flops
`timescale 1ns/1ps
module link_delay_line #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 310
) (
   input wire logic clock, // System clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic [WIDTH-1:0] din, // Sample taken every cycle
   output logic [WIDTH-1:0] dout // Sample from DEPTH+1 cycles ago
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

   initial begin
      if (DEPTH < 1 || WIDTH < 1) begin
         $error("link_delay_line: DEPTH and WIDTH must be at least 1");
      end
   end

   logic [WIDTH-1:0] ring [DEPTH];
   logic [WIDTH-1:0] next_ring [DEPTH];
   logic [PTR_W-1:0] ptr;
   logic [PTR_W-1:0] next_ptr;
   logic [WIDTH-1:0] next_dout;

   always_comb begin
      next_ring = ring;
      next_ring[ptr] = din;
      next_dout = ring[ptr];
      next_ptr = (ptr == LAST) ? '0 : ptr + 1'b1;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < DEPTH; i++) begin
            ring[i] <= '0;
         end
         ptr <= '0;
         dout <= '0;
      end else begin
         ring <= next_ring;
         ptr <= next_ptr;
         dout <= next_dout;
      end
   end

endmodule // link_delay_line

// ===== link_partner_model.sv
// Behavioural model of the sending partner module across the expansion link
`timescale 1ns/1ps
module link_partner_model
   import dual_link_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic [SENSOR_COUNT-1:0] sensors, // Partner sensor levels
   input wire logic [LINK_WIDTH-1:0] progOut, // Partner output byte image
   input wire logic [LINK_WIDTH-1:0] dirOut, // Partner pin directions, 1 output
   output logic [LINK_WIDTH-1:0] pinLevel // Levels the partner puts on the pins
);
   logic [LINK_WIDTH-1:0] drift = 8'h00;

   // Released pins change every cycle so stale levels never pass for data
   always @(posedge clock) begin
      drift <= ~drift;
   end

   always_comb begin
      for (int i = 0; i < LINK_WIDTH; i++) begin
         pinLevel[i] = dirOut[i] ? progOut[i] : drift[i];
      end
      if (dirOut[RESULT_BIT]) begin
         pinLevel[RESULT_BIT] = &sensors;
      end
   end
endmodule // link_partner_model
